//--- rtl/nvsc_cfg.svh
`ifndef NVSC_CFG_SVH
`define NVSC_CFG_SVH
// Functional notes
// - Host holds address stable across the whole write cycle.
// - Host keeps output enable high during writes to avoid contention.
// - Store starts after reads 0000,1555,0AAA,1FFF,10F0,0F0F in order.
// - Recall starts after reads 0000,1555,0AAA,1FFF,10F0,0F0E in order.
// - Host keeps write enable high through all six sequence cycles.
// - Each step is a select-paced read; output enable may stay high.
// - Host must not hold a write state when power-up recall ends.

`define NVSC_CLK_PERIOD_NS     10
`define NVSC_T_STORE_MS        10
`define NVSC_T_RECALL_US       20
`define NVSC_T_RESTORE_US      550
`define NVSC_STORE_CYC    (`NVSC_T_STORE_MS * 1000000 / `NVSC_CLK_PERIOD_NS)
`define NVSC_RECALL_CYC   (`NVSC_T_RECALL_US * 1000 / `NVSC_CLK_PERIOD_NS)
`define NVSC_RESTORE_CYC  (`NVSC_T_RESTORE_US * 1000 / `NVSC_CLK_PERIOD_NS)
// Access phase lengths in clocks (10 ns each)
`define NVSC_SETUP_CYC         2
`define NVSC_PULSE_CYC         4
`define NVSC_HOLD_CYC          2
`define NVSC_SEQ_A0            13'h0000
`define NVSC_SEQ_A1            13'h1555
`define NVSC_SEQ_A2            13'h0AAA
`define NVSC_SEQ_A3            13'h1FFF
`define NVSC_SEQ_A4            13'h10F0
`define NVSC_SEQ_STORE         13'h0F0F
`define NVSC_SEQ_RECALL        13'h0F0E
`endif

//--- rtl/nvsc_pkg.sv
package nvsc_pkg;
	typedef logic [12:0] nvsc_addr_t;
	typedef logic [7:0]  nvsc_data_t;
	typedef enum logic [1:0] {
		NVSC_CMD_READ   = 2'h0,
		NVSC_CMD_WRITE  = 2'h1,
		NVSC_CMD_STORE  = 2'h2,
		NVSC_CMD_RECALL = 2'h3
	} nvsc_cmd_e;
	typedef enum logic [2:0] {
		NVSC_IDLE  = 3'h0,
		NVSC_SETUP = 3'h1,
		NVSC_PULSE = 3'h3,
		NVSC_HOLD  = 3'h2,
		NVSC_NEXT  = 3'h6,
		NVSC_WAIT  = 3'h4
	} nvsc_state_e;
endpackage

//--- rtl/nvsc_seq_rom.sv
`timescale 1ns/1ps
`include "nvsc_cfg.svh"
// Address of each trigger step; the last one picks store or recall
module nvsc_seq_rom (
	input  wire logic [2:0]      step_in,
	input  wire logic            recall_in,
	output nvsc_pkg::nvsc_addr_t addr_out
);
	import nvsc_pkg::*;
	// Fixed six-step order, shared prefix for both operations
	always_comb begin
		unique case (step_in)
			3'h0: addr_out = `NVSC_SEQ_A0;
			3'h1: addr_out = `NVSC_SEQ_A1;
			3'h2: addr_out = `NVSC_SEQ_A2;
			3'h3: addr_out = `NVSC_SEQ_A3;
			3'h4: addr_out = `NVSC_SEQ_A4;
			3'h5: addr_out = recall_in ? `NVSC_SEQ_RECALL : `NVSC_SEQ_STORE;
			default: addr_out = `NVSC_SEQ_A0;
		endcase
	end
endmodule

//--- rtl/nvsc_host.sv
`timescale 1ns/1ps
`include "nvsc_cfg.svh"
// Host-side controller for a byte-wide nonvolatile static memory
module nvsc_host #(
	parameter int STORE_CYC   = `NVSC_STORE_CYC,
	parameter int RESTORE_CYC = `NVSC_RESTORE_CYC
) (
	input  wire logic                 CLK_IN,
	input  wire logic                 RESET_IN,
	input  wire logic                 CE_IN,
	input  wire logic                 REQ_VALID_IN,
	input  nvsc_pkg::nvsc_cmd_e       REQ_CMD_IN,
	input  nvsc_pkg::nvsc_addr_t      REQ_ADDR_IN,
	input  nvsc_pkg::nvsc_data_t      REQ_WDATA_IN,
	input  wire logic                 SUPPLY_LOW_IN,
	output logic                      REQ_READY_OUT,
	output logic                      RSP_VALID_OUT,
	output nvsc_pkg::nvsc_data_t      RSP_RDATA_OUT,
	output logic                      STORE_BLOCKED_OUT,
	output nvsc_pkg::nvsc_addr_t      WORD_ADDRESS_OUT,
	output logic                      SEL_N_OUT,
	output logic                      WR_N_OUT,
	output logic                      OE_N_OUT,
	input  nvsc_pkg::nvsc_data_t      DATA_BUS_IN,
	output nvsc_pkg::nvsc_data_t      DATA_BUS_OUT,
	output logic                      DATA_BUS_OE_OUT
);
	import nvsc_pkg::*;

	localparam int RECALL_CYC = `NVSC_RECALL_CYC;
	// Counter must hold the longest wait, whichever parameter that is
	localparam int LONG_CYC   = (STORE_CYC > RECALL_CYC) ? STORE_CYC : RECALL_CYC;
	localparam int MAX_CYC    = (LONG_CYC > RESTORE_CYC) ? LONG_CYC : RESTORE_CYC;
	localparam int CW         = $clog2(MAX_CYC + 1);

	nvsc_state_e      state, next_state;
	nvsc_cmd_e        cmd, next_cmd;
	nvsc_addr_t       addr, next_addr;
	nvsc_data_t       wdata, next_wdata;
	logic [2:0]       step, next_step;
	logic [CW-1:0]    cnt, next_cnt;
	logic             powerup, next_powerup;
	logic             sel_n, next_sel_n;
	logic             wr_n, next_wr_n;
	logic             oe_n, next_oe_n;
	logic             doe, next_doe;
	logic             rsp, next_rsp;
	nvsc_data_t       rdata, next_rdata;
	logic             blocked, next_blocked;
	nvsc_addr_t       seq_addr;
	logic             is_seq;

	nvsc_seq_rom u_rom (
		.step_in   (step),
		.recall_in (cmd == NVSC_CMD_RECALL),
		.addr_out  (seq_addr)
	);

	assign is_seq            = (cmd == NVSC_CMD_STORE) || (cmd == NVSC_CMD_RECALL);
	assign REQ_READY_OUT     = (state == NVSC_IDLE) && !powerup;
	assign RSP_VALID_OUT     = rsp;
	assign RSP_RDATA_OUT     = rdata;
	assign STORE_BLOCKED_OUT = blocked;
	assign WORD_ADDRESS_OUT  = addr;
	assign SEL_N_OUT         = sel_n;
	assign WR_N_OUT          = wr_n;
	assign OE_N_OUT          = oe_n;
	assign DATA_BUS_OUT      = wdata;
	assign DATA_BUS_OE_OUT   = doe;

	// Access sequencer; the whole trigger runs uninterrupted so nothing intervenes
	always_comb begin
		next_state   = state;
		next_cmd     = cmd;
		next_addr    = addr;
		next_wdata   = wdata;
		next_step    = step;
		next_cnt     = cnt;
		next_powerup = powerup;
		next_sel_n   = sel_n;
		next_wr_n    = wr_n;
		next_oe_n    = oe_n;
		next_doe     = doe;
		next_rsp     = 1'b0;
		next_rdata   = rdata;
		next_blocked = 1'b0;
		unique case (state)
			NVSC_IDLE: begin
				next_sel_n = 1'b1;
				next_wr_n  = 1'b1;
				next_oe_n  = 1'b1;
				next_doe   = 1'b0;
				if (powerup) begin
					// Wait out power-up recall with all strobes idle
					next_cnt   = CW'(RESTORE_CYC);
					next_state = NVSC_WAIT;
				end else if (REQ_VALID_IN) begin
					if (REQ_CMD_IN == NVSC_CMD_STORE && SUPPLY_LOW_IN) begin
						next_blocked = 1'b1;
						next_rsp     = 1'b1;
					end else begin
						next_cmd   = REQ_CMD_IN;
						next_wdata = REQ_WDATA_IN;
						next_step  = 3'h0;
						next_addr  = (REQ_CMD_IN == NVSC_CMD_STORE ||
							REQ_CMD_IN == NVSC_CMD_RECALL) ? `NVSC_SEQ_A0 : REQ_ADDR_IN;
						next_cnt   = CW'(`NVSC_SETUP_CYC);
						next_state = NVSC_SETUP;
					end
				end
			end
			NVSC_SETUP: begin
				// Address settles before select falls
				next_cnt = cnt - CW'(1);
				if (cnt == CW'(1)) begin
					next_sel_n = 1'b0;
					if (cmd == NVSC_CMD_WRITE) begin
						next_wr_n = 1'b0;
						next_doe  = 1'b1;
						next_oe_n = 1'b1;
					end else begin
						next_wr_n = 1'b1;
						next_oe_n = is_seq;
					end
					next_cnt   = CW'(`NVSC_PULSE_CYC);
					next_state = NVSC_PULSE;
				end
			end
			NVSC_PULSE: begin
				next_cnt = cnt - CW'(1);
				if (cnt == CW'(1)) begin
					// Capture before strobes rise; write ends on select edge
					if (cmd == NVSC_CMD_READ)
						next_rdata = DATA_BUS_IN;
					next_sel_n = 1'b1;
					next_oe_n  = 1'b1;
					next_cnt   = CW'(`NVSC_HOLD_CYC);
					next_state = NVSC_HOLD;
				end
			end
			NVSC_HOLD: begin
				// Address and write data held past the rising edge
				next_cnt = cnt - CW'(1);
				if (cnt == CW'(1)) begin
					next_wr_n  = 1'b1;
					next_doe   = 1'b0;
					next_state = NVSC_NEXT;
				end
			end
			NVSC_NEXT: begin
				if (is_seq && step != 3'h5) begin
					next_step  = step + 3'h1;
					next_state = NVSC_SETUP;
					next_cnt   = CW'(`NVSC_SETUP_CYC);
				end else if (is_seq) begin
					// Device busy: no access until the window expires
					next_cnt   = (cmd == NVSC_CMD_STORE) ? CW'(STORE_CYC) : CW'(RECALL_CYC);
					next_state = NVSC_WAIT;
				end else begin
					next_rsp   = 1'b1;
					next_state = NVSC_IDLE;
				end
			end
			NVSC_WAIT: begin
				next_cnt = cnt - CW'(1);
				if (cnt <= CW'(1)) begin
					next_rsp     = !powerup;
					next_powerup = 1'b0;
					next_step    = 3'h0;
					next_state   = NVSC_IDLE;
				end
			end
			default: next_state = NVSC_IDLE;
		endcase
		if (state == NVSC_NEXT && is_seq && step != 3'h5)
			next_addr = seq_addr;
		else if (state == NVSC_NEXT && is_seq)
			next_addr = addr;
	end

	// Sequencer address must lead the step it is issued for
	nvsc_addr_t step_addr;
	nvsc_seq_rom u_rom_next (
		.step_in   (step + 3'h1),
		.recall_in (cmd == NVSC_CMD_RECALL),
		.addr_out  (step_addr)
	);

	// Registers; clock enable freezes everything except the synchronous reset
	always_ff @(posedge CLK_IN) begin
		if (RESET_IN) begin
			state   <= NVSC_IDLE;
			cmd     <= NVSC_CMD_READ;
			addr    <= 13'h0000;
			wdata   <= 8'h00;
			step    <= 3'h0;
			cnt     <= '0;
			powerup <= 1'b1;
			sel_n   <= 1'b1;
			wr_n    <= 1'b1;
			oe_n    <= 1'b1;
			doe     <= 1'b0;
			rsp     <= 1'b0;
			rdata   <= 8'h00;
			blocked <= 1'b0;
		end else if (CE_IN) begin
			state   <= next_state;
			cmd     <= next_cmd;
			addr    <= (state == NVSC_NEXT && is_seq && step != 3'h5) ? step_addr : next_addr;
			wdata   <= next_wdata;
			step    <= next_step;
			cnt     <= next_cnt;
			powerup <= next_powerup;
			sel_n   <= next_sel_n;
			wr_n    <= next_wr_n;
			oe_n    <= next_oe_n;
			doe     <= next_doe;
			rsp     <= next_rsp;
			rdata   <= next_rdata;
			blocked <= next_blocked;
		end
	end
endmodule

//--- sim/nvsc_dev_model.sv
`timescale 1ns/1ps
// Behavioural memory with a nonvolatile shadow, paced by the select strobe
module nvsc_dev_model (
	input  wire logic [12:0] addr_in,
	input  wire logic        sel_n_in,
	input  wire logic        wr_n_in,
	input  wire logic        oe_n_in,
	input  wire logic        low_in,
	input  wire logic [7:0]  data_in,
	output logic      [7:0]  data_out
);
	logic [7:0]  sram [8192];
	logic [7:0]  nv [8192];
	logic [12:0] seq [5] = '{13'h0000, 13'h1555, 13'h0AAA, 13'h1FFF, 13'h10F0};
	int          step = 0;
	logic        busy = 1'h1;
	// Released bus shows the inverse, so a stale byte never passes
	assign data_out = (!sel_n_in && !oe_n_in && wr_n_in && !busy) ? sram[addr_in] : ~sram[addr_in];
	// Power-up recall of a known pattern
	initial begin
		for (int i = 0; i < 8192; i++) begin
			nv[i] = 8'(i) ^ 8'h3C;
			sram[i] = nv[i];
		end
		#100 busy = 1'h0;
	end
	// Byte lands when either strobe rises first
	always @(posedge sel_n_in or posedge wr_n_in) begin
		if ((sel_n_in ^ wr_n_in) && !busy) begin
			sram[addr_in] = data_in;
		end
	end
	// Detector blocks itself while busy, which ignores the pins
	always @(negedge sel_n_in) begin
		if (busy) begin
		end else if (!wr_n_in) begin
			step = 0;
		end else if (step == 5 && addr_in == 13'h0F0E) begin
			busy = 1'h1;
			step = 0;
			for (int i = 0; i < 8192; i++) begin
				sram[i] = 8'h00;
				sram[i] = nv[i];
			end
			#5000 busy = 1'h0;
		end else if (step == 5 && addr_in == 13'h0F0F && !low_in) begin
			busy = 1'h1;
			step = 0;
			for (int i = 0; i < 8192; i++) begin
				nv[i] = 8'hFF;
				nv[i] = sram[i];
			end
			#400 busy = 1'h0;
		end else if (step < 5 && addr_in == seq[step]) begin
			step++;
		end else begin
			step = (addr_in == 13'h0000) ? 1 : 0;
		end
	end
endmodule

//--- sim/nvsc_host_monitor.sv
`timescale 1ns/1ps
// Pin-level checks on the host controller
module nvsc_host_monitor (
	input  wire logic           CLK_IN,
	input  wire logic           RESET_IN,
	input  wire logic           CE_IN,
	input  wire logic           REQ_VALID_IN,
	input  nvsc_pkg::nvsc_cmd_e REQ_CMD_IN,
	input  wire logic           SUPPLY_LOW_IN,
	input  wire logic           REQ_READY_OUT,
	input  wire logic           RSP_VALID_OUT,
	input  wire logic           STORE_BLOCKED_OUT,
	input  nvsc_pkg::nvsc_addr_t WORD_ADDRESS_OUT,
	input  wire logic           SEL_N_OUT,
	input  wire logic           WR_N_OUT,
	input  wire logic           OE_N_OUT,
	input  nvsc_pkg::nvsc_data_t DATA_BUS_OUT,
	input  wire logic           DATA_BUS_OE_OUT
);
	import nvsc_pkg::*;
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);
	// Accepted request decode
	wire take = CE_IN && REQ_VALID_IN && REQ_READY_OUT;
	wire rd = take && REQ_CMD_IN == NVSC_CMD_READ;
	wire wr = take && REQ_CMD_IN == NVSC_CMD_WRITE;
	a_read_strobes: assert property (rd |-> ##3 !SEL_N_OUT && !OE_N_OUT && WR_N_OUT)
		else $error("read strobes late");
	a_write_strobes: assert property (wr |-> ##3 !SEL_N_OUT && !WR_N_OUT && DATA_BUS_OE_OUT)
		else $error("write strobes late");
	a_rsp_latency: assert property ((rd || wr) |=> !RSP_VALID_OUT [*8] ##1 !RSP_VALID_OUT ##1 RSP_VALID_OUT)
		else $error("response timing wrong");
	a_seq_start: assert property (take && (REQ_CMD_IN == NVSC_CMD_RECALL ||
		(REQ_CMD_IN == NVSC_CMD_STORE && !SUPPLY_LOW_IN)) |=> WORD_ADDRESS_OUT == 13'h0000)
		else $error("sequence does not open at first address");
	a_rsp_single: assert property (RSP_VALID_OUT |=> !RSP_VALID_OUT)
		else $error("response too long");
	a_addr_stable: assert property (!SEL_N_OUT || !WR_N_OUT |-> $stable(WORD_ADDRESS_OUT))
		else $error("address moved in cycle");
	a_oe_off_write: assert property (!WR_N_OUT |-> OE_N_OUT)
		else $error("output enable low in write");
	a_seq_wr_high: assert property (!SEL_N_OUT && !DATA_BUS_OE_OUT |-> WR_N_OUT)
		else $error("write strobe in read");
	a_store_block: assert property (take && SUPPLY_LOW_IN && REQ_CMD_IN == NVSC_CMD_STORE
		|=> RSP_VALID_OUT && STORE_BLOCKED_OUT && SEL_N_OUT)
		else $error("store not refused");
	a_wdata_held: assert property (!WR_N_OUT && $past(!WR_N_OUT) |-> $stable(DATA_BUS_OUT))
		else $error("write data moved");
endmodule
bind nvsc_host nvsc_host_monitor mon (.*);

//--- sim/nvsc_host_tb.sv
`timescale 1ns/1ps
// Self-checking bench: host controller against the memory model
module nvsc_host_tb;
	import nvsc_pkg::*;
	logic       CLK_IN;
	logic       RESET_IN;
	logic       CE_IN;
	logic       REQ_VALID_IN;
	nvsc_cmd_e  REQ_CMD_IN;
	nvsc_addr_t REQ_ADDR_IN;
	nvsc_data_t REQ_WDATA_IN;
	logic       SUPPLY_LOW_IN;
	logic       REQ_READY_OUT;
	logic       RSP_VALID_OUT;
	nvsc_data_t RSP_RDATA_OUT;
	logic       STORE_BLOCKED_OUT;
	nvsc_addr_t WORD_ADDRESS_OUT;
	logic       SEL_N_OUT;
	logic       WR_N_OUT;
	logic       OE_N_OUT;
	nvsc_data_t DATA_BUS_OUT;
	logic       DATA_BUS_OE_OUT;
	nvsc_data_t dev_q;
	wire  [7:0] DATA_BUS_IN;
	int         error_cnt = 0;
	int         compares = 0;
	int         cyc = 0;
	// Shared data line: host wins while it drives
	assign DATA_BUS_IN = DATA_BUS_OE_OUT ? DATA_BUS_OUT : dev_q;
	nvsc_host #(.STORE_CYC(50), .RESTORE_CYC(20)) dut (.*);
	nvsc_dev_model dev (.addr_in(WORD_ADDRESS_OUT), .sel_n_in(SEL_N_OUT), .wr_n_in(WR_N_OUT),
		.oe_n_in(OE_N_OUT), .low_in(SUPPLY_LOW_IN), .data_in(DATA_BUS_IN), .data_out(dev_q));
	initial begin
		CLK_IN = 1'h0;
		forever #5 CLK_IN = ~CLK_IN;
	end
	task complete_run;
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Cuts a hang short
	always @(posedge CLK_IN) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run();
		end
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// One request, held until taken, then wait for the response pulse
	task automatic xfer(input nvsc_cmd_e c, input nvsc_addr_t a, input nvsc_data_t d);
		int n;
		@(negedge CLK_IN);
		REQ_CMD_IN = c;
		REQ_ADDR_IN = a;
		REQ_WDATA_IN = d;
		REQ_VALID_IN = 1'h1;
		for (n = 0; n < 100 && REQ_READY_OUT !== 1'h1; n++) @(negedge CLK_IN);
		@(negedge CLK_IN);
		REQ_VALID_IN = 1'h0;
		for (n = 0; n < 3000 && RSP_VALID_OUT !== 1'h1; n++) @(negedge CLK_IN);
		chk({7'h00, RSP_VALID_OUT}, 8'h01);
	endtask
	task t_powerup;
		CE_IN = 1'h0;
		repeat (3) @(negedge CLK_IN);
		CE_IN = 1'h1;
		xfer(NVSC_CMD_READ, 13'h0005, 8'h00);
		chk(RSP_RDATA_OUT, 8'h39);
	endtask
	task t_rw;
		xfer(NVSC_CMD_WRITE, 13'h1FFF, 8'hC3);
		xfer(NVSC_CMD_WRITE, 13'h0123, 8'h5A);
		xfer(NVSC_CMD_READ, 13'h1FFF, 8'h00);
		chk(RSP_RDATA_OUT, 8'hC3);
		xfer(NVSC_CMD_READ, 13'h0123, 8'h00);
		chk(RSP_RDATA_OUT, 8'h5A);
	endtask
	task t_blocked;
		xfer(NVSC_CMD_WRITE, 13'h0007, 8'h77);
		SUPPLY_LOW_IN = 1'h1;
		xfer(NVSC_CMD_STORE, 13'h0000, 8'h00);
		chk({7'h00, STORE_BLOCKED_OUT}, 8'h01);
		SUPPLY_LOW_IN = 1'h0;
		xfer(NVSC_CMD_RECALL, 13'h0000, 8'h00);
		xfer(NVSC_CMD_READ, 13'h0007, 8'h00);
		chk(RSP_RDATA_OUT, 8'h3B);
	endtask
	task t_store_recall;
		xfer(NVSC_CMD_WRITE, 13'h0007, 8'h77);
		xfer(NVSC_CMD_STORE, 13'h0000, 8'h00);
		chk({7'h00, STORE_BLOCKED_OUT}, 8'h00);
		xfer(NVSC_CMD_WRITE, 13'h0007, 8'h11);
		xfer(NVSC_CMD_READ, 13'h0007, 8'h00);
		chk(RSP_RDATA_OUT, 8'h11);
		for (int k = 0; k < 2; k++) begin
			xfer(NVSC_CMD_RECALL, 13'h0000, 8'h00);
			xfer(NVSC_CMD_READ, 13'h0007, 8'h00);
			chk(RSP_RDATA_OUT, 8'h77);
			xfer(NVSC_CMD_WRITE, 13'h0007, 8'h22);
		end
	endtask
	initial begin
		RESET_IN = 1'h1;
		CE_IN = 1'h1;
		REQ_VALID_IN = 1'h0;
		REQ_CMD_IN = NVSC_CMD_READ;
		REQ_ADDR_IN = 13'h0000;
		REQ_WDATA_IN = 8'h00;
		SUPPLY_LOW_IN = 1'h0;
		repeat (16) @(negedge CLK_IN);
		RESET_IN = 1'h0;
		t_powerup();
		t_rw();
		t_blocked();
		t_store_recall();
		complete_run();
	end
endmodule
